/* dls_pkg.sv */
// dls_pkg.sv: constants, types and helpers of the channel loop sequencer
// assumes a single 40 MHz clock (25 ns) shared by every user of the package
package dls_pkg;
  localparam int NCH = 4;
  localparam int CHW = 2;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int FW = 4;
  localparam int CW = 15;
  localparam int OW = 16;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 16;
  // field selectors of the register port
  localparam logic [FW-1:0] F_SADDR = 4'h0;
  localparam logic [FW-1:0] F_SOFF = 4'h1;
  localparam logic [FW-1:0] F_NBYTES = 4'h2;
  localparam logic [FW-1:0] F_SLAST = 4'h3;
  localparam logic [FW-1:0] F_DADDR = 4'h4;
  localparam logic [FW-1:0] F_DOFF = 4'h5;
  localparam logic [FW-1:0] F_CITER = 4'h6;
  localparam logic [FW-1:0] F_DLAST = 4'h7;
  localparam logic [FW-1:0] F_BITER = 4'h8;
  localparam logic [FW-1:0] F_CTRL = 4'h9;
  // bit positions inside packed fields
  localparam int SIZE_LSB = 24;
  localparam int SIZE_MSB = 25;
  localparam int CTL_START = 0;
  localparam int CTL_INTMAJ = 1;
  localparam int CTL_ACTIVE = 6;
  localparam int CTL_DONE = 7;
  // transfer width codes and fixed values
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [CW-1:0] CITER_LAST = 15'h0001;
  localparam logic [DW-1:0] ZERO_W = 32'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB = 3'h1,
    ST_LOAD = 3'h3,
    ST_READ = 3'h2,
    ST_WRITE = 3'h6,
    ST_WB = 3'h7
  } dls_state_t;
  // bytes moved by one access of a width code
  function automatic logic [2:0] size_bytes(input logic [1:0] code);
    return (code == SZ_BYTE) ? 3'h1 : (code == SZ_HALF) ? 3'h2 : 3'h4;
  endfunction
  // bytes in one read/write group, the larger of both widths
  function automatic logic [2:0] unit_of(input logic [1:0] s,
                                         input logic [1:0] d);
    return (size_bytes(s) > size_bytes(d)) ? size_bytes(s) : size_bytes(d);
  endfunction
  // keeps only the lanes of one access
  function automatic logic [DW-1:0] size_mask(input logic [1:0] code);
    return (code == SZ_BYTE) ? 32'h0000_00FF :
           (code == SZ_HALF) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  endfunction
  // widens a signed offset to address width
  function automatic logic [AW-1:0] sext(input logic [OW-1:0] off);
    return {{(AW - OW){off[OW-1]}}, off};
  endfunction
endpackage

/* dls_fifo.sv */
// dls_fifo.sv: data buffer between source reads and destination writes
// assumes both sides on clk_i; valid/ready handshake on both ends
`timescale 1ns/1ps
module dls_fifo #(
  parameter int W = dls_pkg::FIFO_W,
  parameter int D = dls_pkg::FIFO_D
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  import dls_pkg::*;
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // honest full and empty from the fill count
  assign in_ready_o = cnt_reg != (PW + 1)'(D);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem[rp_reg];
  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
  // storage array
  always_ff @(posedge clk_i) begin
    if (push) mem[wp_reg] <= in_data_i;
  end
endmodule

/* dls_sequencer.sv */
// dls_sequencer.sv: descriptor-driven channel loop sequencer
// assumes bus, register port and status ports all run on clk_i
`timescale 1ns/1ps
module dls_sequencer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic arb_fixed_i,
  input wire logic [dls_pkg::NCH-1:0] preempt_en_i,
  input wire logic reg_req_i,
  input wire logic reg_we_i,
  input wire logic [dls_pkg::CHW-1:0] reg_ch_i,
  input wire logic [dls_pkg::FW-1:0] reg_field_i,
  input wire logic [dls_pkg::DW-1:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic [dls_pkg::DW-1:0] reg_rdata_o,
  output logic bus_req_o,
  output logic bus_we_o,
  output logic [dls_pkg::AW-1:0] bus_addr_o,
  output logic [1:0] bus_size_o,
  output logic [dls_pkg::DW-1:0] bus_wdata_o,
  input wire logic bus_ack_i,
  input wire logic [dls_pkg::DW-1:0] bus_rdata_i,
  input wire logic [dls_pkg::NCH-1:0] irq_clear_i,
  output logic [dls_pkg::NCH-1:0] channel_irq_flags_o,
  output logic irq_o,
  output logic [dls_pkg::NCH-1:0] active_o,
  output logic [dls_pkg::NCH-1:0] done_o,
  output logic busy_o
);
  import dls_pkg::*;

  // descriptor memory, one entry per channel
  logic [AW-1:0] m_saddr [NCH];
  logic [AW-1:0] m_daddr [NCH];
  logic [AW-1:0] m_slast [NCH];
  logic [AW-1:0] m_dlast [NCH];
  logic [DW-1:0] m_nbytes [NCH];
  logic [OW-1:0] m_soff [NCH];
  logic [OW-1:0] m_doff [NCH];
  logic [1:0] m_ssize [NCH];
  logic [1:0] m_dsize [NCH];
  logic [CW-1:0] m_citer [NCH];
  logic [CW-1:0] m_biter [NCH];
  logic [NCH-1:0] start_reg;
  logic [NCH-1:0] active_reg;
  logic [NCH-1:0] done_reg;
  logic [NCH-1:0] intmaj_reg;
  logic [NCH-1:0] irqf_reg;

  // working set of the executing channel
  dls_state_t state_reg;
  dls_state_t state_next;
  logic [CHW-1:0] sel_ch;
  logic [CHW-1:0] rr_last;
  logic [AW-1:0] w_saddr;
  logic [AW-1:0] w_daddr;
  logic [DW-1:0] w_nbytes;
  logic [CW-1:0] w_citer;
  logic [DW-1:0] acc_reg;
  logic [DW-1:0] wbuf_reg;
  logic wbuf_vld;
  logic [2:0] fill_reg;
  logic [2:0] rd_left;
  logic [2:0] wr_left;

  // suspended channel while another one preempts it
  logic held_vld;
  logic [CHW-1:0] held_ch;
  logic [AW-1:0] held_saddr;
  logic [AW-1:0] held_daddr;
  logic [DW-1:0] held_nbytes;
  logic [CW-1:0] held_citer;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DW-1:0] fifo_out_data;

  // winner: later candidates override earlier ones
  function automatic logic [CHW:0] pick_ch(input logic [NCH-1:0] req,
                                           input logic fixed,
                                           input logic [CHW-1:0] last);
    logic [CHW:0] r;
    logic [CHW-1:0] c;
    r = '0;
    for (int i = 0; i < NCH; i++) begin
      c = fixed ? CHW'(i) : last - CHW'(i);
      if (req[c]) r = {1'b1, c};
    end
    return r;
  endfunction

  // any request above a channel in fixed priority
  function automatic logic higher_req(input logic [NCH-1:0] req,
                                      input logic [CHW-1:0] ch);
    logic h;
    h = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (req[i] && CHW'(i) > ch) h = 1'b1;
    end
    return h;
  endfunction

  // decode of the current channel and its steps
  wire [CHW:0] win = pick_ch(start_reg, arb_fixed_i, rr_last);
  wire [1:0] ssz = m_ssize[sel_ch];
  wire [1:0] dsz = m_dsize[sel_ch];
  wire [2:0] sb = size_bytes(ssz);
  wire [2:0] db = size_bytes(dsz);
  wire [2:0] unit = unit_of(ssz, dsz);
  wire [2:0] rd_init = unit >> ssz;
  wire [2:0] rd_init_h = unit_of(m_ssize[held_ch], m_dsize[held_ch])
                         >> m_ssize[held_ch];
  wire [AW-1:0] saddr_step = w_saddr + sext(m_soff[sel_ch]);
  wire [AW-1:0] daddr_step = w_daddr + sext(m_doff[sel_ch]);
  wire [DW-1:0] nbytes_step = w_nbytes - DW'(sb);
  wire [DW-1:0] rd_lane = (bus_rdata_i & size_mask(ssz)) << {fill_reg, 3'h0};
  wire [AW-1:0] saddr_fin = w_saddr + m_slast[sel_ch];
  wire [AW-1:0] daddr_fin = w_daddr + m_dlast[sel_ch];
  wire [CW-1:0] biter_sel = m_biter[sel_ch];
  wire maj_end = w_citer == CITER_LAST;
  wire min_end = w_nbytes == ZERO_W;
  wire rd_go = state_reg == ST_READ && rd_left != '0;
  wire wr_go = state_reg == ST_WRITE && wbuf_vld;
  wire wr_last = wr_go && bus_ack_i && wr_left == 3'h1;
  wire preempt = arb_fixed_i && preempt_en_i[sel_ch] && !held_vld
                 && higher_req(start_reg, sel_ch);
  wire eng_mem = state_reg == ST_LOAD || state_reg == ST_WB;
  wire reg_wr = reg_ack_o && reg_we_i;

  // register port stalls while the engine owns descriptor memory
  assign reg_ack_o = reg_req_i && !eng_mem;

  // bus master outputs, data from flip-flops
  assign bus_req_o = rd_go || wr_go;
  assign bus_we_o = state_reg == ST_WRITE;
  assign bus_addr_o = bus_we_o ? w_daddr : w_saddr;
  assign bus_size_o = bus_we_o ? dsz : ssz;
  assign bus_wdata_o = wbuf_reg;

  // read groups push one packed word; writes drain it
  assign fifo_in_valid = state_reg == ST_READ && rd_left == '0;
  assign fifo_out_ready = state_reg == ST_WRITE && !wbuf_vld;

  // status ports
  assign channel_irq_flags_o = irqf_reg;
  assign irq_o = |(irqf_reg & intmaj_reg);
  assign active_o = active_reg;
  assign done_o = done_reg;
  assign busy_o = state_reg != ST_IDLE;

  dls_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(acc_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // channel sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (|start_reg) state_next = ST_ARB;
      ST_ARB: state_next = win[CHW] ? ST_LOAD : ST_IDLE;
      ST_LOAD: state_next = (m_nbytes[sel_ch] == ZERO_W) ? ST_WB : ST_READ;
      ST_READ: if (rd_left == '0 && fifo_in_ready) state_next = ST_WRITE;
      ST_WRITE: begin
        if (wr_last) begin
          if (nbytes_step == w_nbytes && min_end) state_next = ST_WB;
          else if (min_end) state_next = ST_WB;
          else if (preempt) state_next = ST_ARB;
          else state_next = ST_READ;
        end
      end
      ST_WB: state_next = held_vld ? ST_READ : ST_ARB;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // working set, packing and unpacking
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_ch <= '0;
      rr_last <= '0;
      w_saddr <= '0;
      w_daddr <= '0;
      w_nbytes <= '0;
      w_citer <= '0;
      acc_reg <= '0;
      wbuf_reg <= '0;
      wbuf_vld <= 1'b0;
      fill_reg <= '0;
      rd_left <= '0;
      wr_left <= '0;
    end else begin
      case (state_reg)
        ST_ARB: begin
          if (win[CHW]) begin
            sel_ch <= win[CHW-1:0];
            rr_last <= win[CHW-1:0];
          end
        end
        ST_LOAD: begin
          w_saddr <= m_saddr[sel_ch];
          w_daddr <= m_daddr[sel_ch];
          w_nbytes <= m_nbytes[sel_ch];
          w_citer <= m_citer[sel_ch];
          rd_left <= rd_init;
          fill_reg <= '0;
          acc_reg <= '0;
        end
        ST_READ: begin
          if (rd_left != '0 && bus_ack_i) begin
            acc_reg <= acc_reg | rd_lane;
            fill_reg <= fill_reg + sb;
            w_saddr <= saddr_step;
            w_nbytes <= nbytes_step;
            rd_left <= rd_left - 3'h1;
          end else if (rd_left == '0 && fifo_in_ready) begin
            acc_reg <= '0;
            fill_reg <= '0;
          end
        end
        ST_WRITE: begin
          if (!wbuf_vld) begin
            if (fifo_out_valid) begin
              wbuf_reg <= fifo_out_data;
              wbuf_vld <= 1'b1;
              wr_left <= unit >> dsz;
            end
          end else if (bus_ack_i) begin
            wbuf_reg <= wbuf_reg >> {db, 3'h0};
            w_daddr <= daddr_step;
            wr_left <= wr_left - 3'h1;
            if (wr_left == 3'h1) begin
              wbuf_vld <= 1'b0;
              rd_left <= rd_init;
            end
          end
        end
        ST_WB: begin
          if (held_vld) begin
            sel_ch <= held_ch;
            w_saddr <= held_saddr;
            w_daddr <= held_daddr;
            w_nbytes <= held_nbytes;
            w_citer <= held_citer;
            rd_left <= rd_init_h;
            fill_reg <= '0;
          end
        end
        default: ;
      endcase
    end
  end

  // suspension of a preempted channel
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      held_vld <= 1'b0;
      held_ch <= '0;
      held_saddr <= '0;
      held_daddr <= '0;
      held_nbytes <= '0;
      held_citer <= '0;
    end else if (wr_last && !min_end && preempt) begin
      held_vld <= 1'b1;
      held_ch <= sel_ch;
      held_saddr <= w_saddr;
      held_daddr <= daddr_step;
      held_nbytes <= w_nbytes;
      held_citer <= w_citer;
    end else if (state_reg == ST_WB && held_vld) begin
      held_vld <= 1'b0;
    end
  end

  // channel flags; hardware sets win over clears
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_reg <= '0;
      active_reg <= '0;
      done_reg <= '0;
      intmaj_reg <= '0;
      irqf_reg <= '0;
    end else begin
      irqf_reg <= irqf_reg & ~irq_clear_i;
      if (state_reg == ST_LOAD) begin
        start_reg[sel_ch] <= 1'b0;
        done_reg[sel_ch] <= 1'b0;
        active_reg[sel_ch] <= 1'b1;
      end else if (state_reg == ST_WB) begin
        active_reg[sel_ch] <= 1'b0;
        if (maj_end) begin
          done_reg[sel_ch] <= 1'b1;
          irqf_reg[sel_ch] <= 1'b1;
        end
      end else if (reg_wr && reg_field_i == F_CTRL) begin
        start_reg[reg_ch_i] <= reg_wdata_i[CTL_START];
        intmaj_reg[reg_ch_i] <= reg_wdata_i[CTL_INTMAJ];
        if (!reg_wdata_i[CTL_DONE]) done_reg[reg_ch_i] <= 1'b0;
      end
    end
  end

  // descriptor memory: engine write-back first, then register writes
  always_ff @(posedge clk_i) begin
    if (state_reg == ST_WB) begin
      m_saddr[sel_ch] <= maj_end ? saddr_fin : w_saddr;
      m_daddr[sel_ch] <= maj_end ? daddr_fin : w_daddr;
      m_citer[sel_ch] <= maj_end ? biter_sel : w_citer - CITER_LAST;
    end else if (reg_wr) begin
      case (reg_field_i)
        F_SADDR: m_saddr[reg_ch_i] <= reg_wdata_i;
        F_SOFF: begin
          m_soff[reg_ch_i] <= reg_wdata_i[OW-1:0];
          m_ssize[reg_ch_i] <= reg_wdata_i[SIZE_MSB:SIZE_LSB];
        end
        F_NBYTES: m_nbytes[reg_ch_i] <= reg_wdata_i;
        F_SLAST: m_slast[reg_ch_i] <= reg_wdata_i;
        F_DADDR: m_daddr[reg_ch_i] <= reg_wdata_i;
        F_DOFF: begin
          m_doff[reg_ch_i] <= reg_wdata_i[OW-1:0];
          m_dsize[reg_ch_i] <= reg_wdata_i[SIZE_MSB:SIZE_LSB];
        end
        F_CITER: m_citer[reg_ch_i] <= reg_wdata_i[CW-1:0];
        F_DLAST: m_dlast[reg_ch_i] <= reg_wdata_i;
        F_BITER: m_biter[reg_ch_i] <= reg_wdata_i[CW-1:0];
        default: ;
      endcase
    end
  end

  // read selection: live values for an executing or held channel
  wire live_cur = reg_ch_i == sel_ch
                  && (state_reg == ST_READ || state_reg == ST_WRITE);
  wire live_held = held_vld && reg_ch_i == held_ch;
  wire live = live_cur || live_held;
  wire [AW-1:0] lv_saddr = live_held ? held_saddr : w_saddr;
  wire [AW-1:0] lv_daddr = live_held ? held_daddr : w_daddr;
  wire [DW-1:0] lv_nbytes = live_held ? held_nbytes : w_nbytes;
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = ZERO_W;
    case (reg_field_i)
      F_SADDR: rd_mux = live ? lv_saddr : m_saddr[reg_ch_i];
      F_DADDR: rd_mux = live ? lv_daddr : m_daddr[reg_ch_i];
      F_NBYTES: rd_mux = live ? lv_nbytes : m_nbytes[reg_ch_i];
      F_SOFF: begin
        rd_mux[OW-1:0] = m_soff[reg_ch_i];
        rd_mux[SIZE_MSB:SIZE_LSB] = m_ssize[reg_ch_i];
      end
      F_DOFF: begin
        rd_mux[OW-1:0] = m_doff[reg_ch_i];
        rd_mux[SIZE_MSB:SIZE_LSB] = m_dsize[reg_ch_i];
      end
      F_SLAST: rd_mux = m_slast[reg_ch_i];
      F_DLAST: rd_mux = m_dlast[reg_ch_i];
      F_CITER: rd_mux[CW-1:0] = m_citer[reg_ch_i];
      F_BITER: rd_mux[CW-1:0] = m_biter[reg_ch_i];
      F_CTRL: begin
        rd_mux[CTL_START] = start_reg[reg_ch_i];
        rd_mux[CTL_INTMAJ] = intmaj_reg[reg_ch_i];
        rd_mux[CTL_ACTIVE] = active_reg[reg_ch_i];
        rd_mux[CTL_DONE] = done_reg[reg_ch_i];
      end
      default: rd_mux = ZERO_W;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) reg_rdata_o <= '0;
    else if (reg_ack_o && !reg_we_i) reg_rdata_o <= rd_mux;
  end

  // checks on the sequencing
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_push;
    fifo_in_valid && fifo_in_ready;
  endsequence
  sequence s_drain_start;
    state_reg == ST_WRITE && !wbuf_vld && !bus_req_o;
  endsequence
  sequence s_major_wb;
    state_reg == ST_WB && maj_end;
  endsequence

  AST_BUS_ONLY_SELECTED: assert property (
    bus_req_o |-> active_reg[sel_ch] && state_reg != ST_ARB)
    else $error("bus access without a selected active channel");
  AST_ACTIVATE_FLAGS: assert property (
    state_reg == ST_LOAD |=>
      active_reg[$past(sel_ch)] && !start_reg[$past(sel_ch)]
      && !done_reg[$past(sel_ch)])
    else $error("activation did not set active and clear flags");
  AST_LOAD_COUNT: assert property (
    state_reg == ST_LOAD |=> w_citer == m_citer[sel_ch])
    else $error("working iteration count not loaded");
  AST_SRC_STEP: assert property (
    rd_go && bus_ack_i |=> w_saddr == $past(saddr_step))
    else $error("source address not stepped by offset");
  AST_NBYTES_DOWN: assert property (
    rd_go && bus_ack_i |=> w_nbytes == $past(nbytes_step)
      && w_nbytes < $past(w_nbytes))
    else $error("live byte count did not fall");
  AST_MINOR_RETIRE: assert property (
    state_reg == ST_WB && !maj_end |=>
      !active_reg[$past(sel_ch)] && !done_reg[$past(sel_ch)]
      && m_citer[$past(sel_ch)] == $past(w_citer) - CITER_LAST)
    else $error("minor loop retire wrong");
  AST_FINAL_ADJUST: assert property (
    s_major_wb |=> m_saddr[$past(sel_ch)] == $past(saddr_fin)
      && m_citer[$past(sel_ch)] == $past(biter_sel))
    else $error("final adjustment or reload missing");
  AST_MAJOR_DONE: assert property (
    s_major_wb |=> done_reg[$past(sel_ch)] && irqf_reg[$past(sel_ch)]
      && !active_reg[$past(sel_ch)])
    else $error("major completion flags wrong");
  AST_ARB_NEXT: assert property (
    state_reg == ST_IDLE && |start_reg |=> state_reg == ST_ARB)
    else $error("arbitration not in the cycle after a request");
  AST_ENGINE_WINS: assert property (
    reg_req_i && eng_mem |-> !reg_ack_o)
    else $error("register access not stalled during engine use");
  AST_HELD_ACTIVE: assert property (
    held_vld |-> active_reg[held_ch]
      && (state_reg == ST_ARB || held_ch != sel_ch))
    else $error("suspended channel lost its active flag");
  AST_READ_THEN_WRITE: assert property (
    s_push |=> s_drain_start ##1 wbuf_vld)
    else $error("buffered word not drained before writes");
endmodule

/* dls_mem_model.sv */
// dls_mem_model.sv: system bus memory answering the sequencer
// assumes requests held until ack; byte data derives from the address
`timescale 1ns/1ps
module dls_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [1:0] wait_reg;
  logic [31:0] last_reg;
  // ack at once, or after three wait cycles when slow
  assign ack_o = req_i && (!slow_i || wait_reg == 2'h3);
  // data only with ack, otherwise the inverse of the last value
  assign rdata_o = ack_o ? {24'h0, addr_i[7:0] ^ 8'h5A} : ~last_reg;
  // wait counter restarts at each completed access
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || ack_o || !req_i) begin
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
    if (!rst_n_i) begin
      last_reg <= 32'h0;
    end else if (ack_o) begin
      last_reg <= rdata_o;
    end
  end
endmodule

/* dls_sequencer_tb.sv */
// dls_sequencer_tb.sv: self-checking bench of the channel loop sequencer
// assumes dls_mem_model answers the bus; inputs driven on clk_i
`timescale 1ns/1ps
module dls_sequencer_tb;
  import dls_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic arb_fixed_i = 1'b1;
  logic slow = 1'b0;
  logic [NCH-1:0] preempt_en_i = '0;
  logic [NCH-1:0] irq_clear_i = '0;
  logic reg_req_i = 1'b0;
  logic reg_we_i = 1'b0;
  logic [CHW-1:0] reg_ch_i = '0;
  logic [FW-1:0] reg_field_i = '0;
  logic [DW-1:0] reg_wdata_i = '0;
  logic reg_ack_o, bus_req_o, bus_we_o, bus_ack_i, irq_o, busy_o;
  logic [DW-1:0] reg_rdata_o, bus_wdata_o, bus_rdata_i, rd;
  logic [AW-1:0] bus_addr_o;
  logic [1:0] bus_size_o, wsz;
  logic [NCH-1:0] channel_irq_flags_o, active_o, done_o;
  logic [DW-1:0] wq[$];
  logic [AW-1:0] aq[$];
  int error_cnt = 0;
  int n_tests = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  dls_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .arb_fixed_i(arb_fixed_i), .preempt_en_i(preempt_en_i),
    .reg_req_i(reg_req_i), .reg_we_i(reg_we_i), .reg_ch_i(reg_ch_i),
    .reg_field_i(reg_field_i), .reg_wdata_i(reg_wdata_i),
    .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o),
    .bus_req_o(bus_req_o), .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o),
    .bus_size_o(bus_size_o), .bus_wdata_o(bus_wdata_o),
    .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i),
    .irq_clear_i(irq_clear_i), .channel_irq_flags_o(channel_irq_flags_o),
    .irq_o(irq_o), .active_o(active_o), .done_o(done_o), .busy_o(busy_o));
  dls_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .req_i(bus_req_o), .addr_i(bus_addr_o), .ack_o(bus_ack_i),
    .rdata_o(bus_rdata_i));
  // capture completed destination writes
  always @(posedge clk_i) begin
    if (bus_req_o === 1'b1 && bus_ack_i === 1'b1 && bus_we_o === 1'b1) begin
      aq.push_back(bus_addr_o);
      wq.push_back(bus_wdata_o);
      wsz <= bus_size_o;
    end
  end
  // expected packed word of four byte reads, first byte low
  function automatic logic [31:0] pat(input logic [7:0] a);
    return {a + 8'h3, a + 8'h2, a + 8'h1, a} ^ 32'h5A5A_5A5A;
  endfunction
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one register access, held until acknowledged; read data into rd
  task automatic acc(input logic we, input logic [CHW-1:0] ch,
                     input logic [FW-1:0] f, input logic [DW-1:0] d);
    int i;
    @(posedge clk_i);
    reg_req_i <= 1'b1;
    reg_we_i <= we;
    reg_ch_i <= ch;
    reg_field_i <= f;
    reg_wdata_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (reg_ack_o !== 1'b1 && i < 50);
    reg_req_i <= 1'b0;
    #1 rd = reg_rdata_o;
    chk(32'(i < 50), 32'h1);
    if (i >= 50) finish_test();
  endtask
  // bounded wait for a channel's active flag
  task automatic wact(input int ch, input logic v);
    int i;
    for (i = 0; i < 4000 && active_o[ch] !== v; i++) @(posedge clk_i);
    if (i >= 4000) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask
  // bytes to words, 16 bytes per iteration; start field left out
  task automatic desc(input logic [CHW-1:0] ch, input logic [AW-1:0] s,
    input logic [AW-1:0] d, input logic [CW-1:0] it, input logic [DW-1:0] l);
    acc(1'b1, ch, F_SADDR, s);
    acc(1'b1, ch, F_SOFF, 32'h0000_0001);
    acc(1'b1, ch, F_NBYTES, 32'h0000_0010);
    acc(1'b1, ch, F_SLAST, l);
    acc(1'b1, ch, F_DADDR, d);
    acc(1'b1, ch, F_DOFF, 32'h0200_0004);
    acc(1'b1, ch, F_CITER, {17'h0, it});
    acc(1'b1, ch, F_DLAST, l);
    acc(1'b1, ch, F_BITER, {17'h0, it});
  endtask
  task automatic t_single();
    desc(2'h0, 32'h1000, 32'h2000, 15'h1, 32'hFFFF_FFF0);
    acc(1'b1, 2'h0, F_CTRL, 32'h3);
    wact(0, 1'b1);
    wact(0, 1'b0);
    chk(32'(aq.size()), 32'h4);
    for (int k = 0; k < 4; k++) begin
      chk(aq[k], 32'h2000 + 4 * k);
      chk(wq[k], pat(8'h4 * k));
    end
    chk({30'h0, wsz}, {30'h0, SZ_WORD});
    chk({28'h0, active_o[0], done_o[0], channel_irq_flags_o[0],
         irq_o}, 32'h7);
    acc(1'b0, 2'h0, F_CTRL, 32'h0);
    chk(rd & 32'hC3, 32'h82);
    acc(1'b0, 2'h0, F_SADDR, 32'h0);
    chk(rd, 32'h1000);
    acc(1'b0, 2'h0, F_CITER, 32'h0);
    chk(rd, 32'h1);
    @(posedge clk_i);
    irq_clear_i <= 4'h1;
    @(posedge clk_i);
    irq_clear_i <= 4'h0;
    @(posedge clk_i);
    chk({30'h0, irq_o, busy_o}, 32'h0);
    $display("test single done");
  endtask
  task automatic t_multi();
    @(posedge clk_i);
    slow <= 1'b1;
    wq.delete();
    aq.delete();
    desc(2'h2, 32'h1000, 32'h2000, 15'h2, 32'hFFFF_FFE0);
    acc(1'b1, 2'h2, F_CTRL, 32'h1);
    wact(2, 1'b1);
    for (int k = 0; k < 500 && wq.size() == 0; k++) @(posedge clk_i);
    chk(32'(wq.size() != 0), 32'h1);
    acc(1'b0, 2'h2, F_NBYTES, 32'h0);
    chk(32'(rd inside {[8:12]}), 32'h1);
    acc(1'b0, 2'h2, F_SOFF, 32'h0);
    chk(rd, 32'h1);
    acc(1'b0, 2'h2, F_SADDR, 32'h0);
    chk(32'(rd inside {[32'h1004:32'h1008]}), 32'h1);
    wact(2, 1'b0);
    chk({30'h0, done_o[2], channel_irq_flags_o[2]}, 32'h0);
    acc(1'b0, 2'h2, F_DADDR, 32'h0);
    chk(rd, 32'h2010);
    acc(1'b0, 2'h2, F_CTRL, 32'h0);
    chk(rd & 32'hC1, 32'h0);
    acc(1'b1, 2'h2, F_CTRL, 32'h1);
    wact(2, 1'b1);
    wact(2, 1'b0);
    chk(aq[4], 32'h2010);
    acc(1'b0, 2'h2, F_CITER, 32'h0);
    chk(rd, 32'h2);
    chk({29'h0, done_o[2], channel_irq_flags_o[2], irq_o}, 32'h6);
    $display("test multi done");
  endtask
  task automatic t_preempt();
    @(posedge clk_i);
    preempt_en_i <= 4'h2;
    desc(2'h3, 32'h3000, 32'h4000, 15'h1, 32'hFFFF_FFF0);
    acc(1'b1, 2'h3, F_CTRL, 32'h0);
    desc(2'h1, 32'h1000, 32'h2000, 15'h1, 32'hFFFF_FFF0);
    acc(1'b1, 2'h1, F_CTRL, 32'h1);
    wact(1, 1'b1);
    acc(1'b1, 2'h3, F_CTRL, 32'h1);
    wact(3, 1'b1);
    chk({28'h0, active_o}, 32'hA);
    wact(3, 1'b0);
    chk({24'h0, active_o, done_o}, 32'h2D);
    wact(1, 1'b0);
    chk({28'h0, done_o}, 32'hF);
    $display("test preempt done");
  endtask
  // round robin: after channel 3, channel 0 goes before channel 2
  task automatic t_rrobin();
    @(posedge clk_i);
    arb_fixed_i <= 1'b0;
    acc(1'b1, 2'h3, F_CTRL, 32'h1);
    wact(3, 1'b1);
    acc(1'b1, 2'h2, F_CTRL, 32'h1);
    acc(1'b1, 2'h0, F_CTRL, 32'h1);
    wact(3, 1'b0);
    wact(0, 1'b1);
    chk({28'h0, active_o}, 32'h1);
    wact(0, 1'b0);
    wact(2, 1'b1);
    wact(2, 1'b0);
    chk({28'h0, done_o}, 32'hB);
    $display("test round robin done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk_i);
    chk({18'h0, active_o, done_o, channel_irq_flags_o, busy_o, irq_o}, 32'h0);
    rst_n_i <= 1'b1;
    t_single();
    t_multi();
    t_preempt();
    t_rrobin();
    finish_test();
  end
endmodule
